/* File: ppb_defines.vh */
// Constants of the parallel I/O port bank: geometry, register map, fields.
// Assumes inclusion by bare name from the bank's design files.
`ifndef PPB_DEFINES_VH
`define PPB_DEFINES_VH

// ----------------------------------------
// Port geometry
// ----------------------------------------
`define PPB_W_BIDIR0   8
`define PPB_W_BIDIR1   8
`define PPB_W_BIDIR2   14
`define PPB_W_BIDIR3   4
`define PPB_W_BIDIR4   3
`define PPB_W_BIDIR5   5
`define PPB_W_BIDIR6   16
`define PPB_W_INONLY0  11
`define PPB_W_INONLY1  5
`define PPB_N_ALT      3
`define PPB_N_ALTIN    16

// ----------------------------------------
// Register map: addr[9:7] kind, addr[6:0] index
// ----------------------------------------
`define PPB_ADDR_W     10
`define PPB_DATA_W     16
`define PPB_KIND_MSB   9
`define PPB_KIND_LSB   7
`define PPB_IDX_W      7
`define PPB_KIND_DATA  3'h0
`define PPB_KIND_CFG   3'h1
`define PPB_KIND_ROUTE 3'h2

// ----------------------------------------
// Line configuration fields
// ----------------------------------------
`define PPB_CFG_W      9
`define PPB_CFG_DIR    0
`define PPB_CFG_OD     1
`define PPB_CFG_PEN    2
`define PPB_CFG_PUP    3
`define PPB_CFG_SLOW   4
`define PPB_CFG_DRV_LO 5
`define PPB_CFG_DRV_HI 6
`define PPB_CFG_ALT_LO 7
`define PPB_CFG_ALT_HI 8
`define PPB_CFG_RST    9'h000
`define PPB_CFG_INMASK 9'h00C

// ----------------------------------------
// Data register fields
// ----------------------------------------
`define PPB_DAT_IN     0
`define PPB_DAT_OUT    1
`define PPB_DAT_RST    1'b0

`endif

/* File: ppb_line.v */
// One port line: output latch, configuration, input synchroniser, pad control.
// Assumes pad inputs synchronous-capable and write strobes decoded by the bank.
`include "ppb_defines.vh"

module ppb_line #(
  parameter HAS_OUT = 1,
  parameter NALT    = `PPB_N_ALT
) (
  // Clock and reset
  input  wire                  clk,
  input  wire                  rstn,
  // Register side
  input  wire                  cfgWr,
  input  wire                  dataWr,
  input  wire [`PPB_CFG_W-1:0] wdata,
  output reg  [`PPB_CFG_W-1:0] cfgQ,
  output reg                   dataQ,
  output wire                  syncIn,
  // Alternate functions
  input  wire [NALT-1:0]       altOut,
  input  wire [NALT-1:0]       altOe,
  // Pad side
  input  wire                  padIn,
  output wire                  padOut,
  output wire                  padOeN,
  output wire                  pullUpEn,
  output wire                  pullDnEn,
  output wire                  slowEdge,
  output wire [1:0]            drive
);

  reg        sync1_q;
  reg        sync2_q;
  reg        altVal;
  reg        altDir;
  reg        claimed;
  wire [1:0] altSel;
  wire       val;
  wire       dir;
  wire       active;
  integer    k;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      cfgQ    <= `PPB_CFG_RST;
      dataQ   <= `PPB_DAT_RST;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      if (cfgWr)
        cfgQ <= (HAS_OUT != 0) ? wdata : (wdata & `PPB_CFG_INMASK);
      if (dataWr && HAS_OUT != 0)
        dataQ <= wdata[0];
      sync1_q <= padIn;
      sync2_q <= sync1_q;
    end
  end

  assign syncIn = sync2_q;

  // ----------------------------------------
  // Alternate function select
  // ----------------------------------------
  assign altSel = cfgQ[`PPB_CFG_ALT_HI:`PPB_CFG_ALT_LO];

  always @* begin
    altVal  = 1'b0;
    altDir  = 1'b0;
    claimed = 1'b0;
    for (k = 0; k < NALT; k = k + 1) begin
      if (altSel == k + 1) begin
        altVal  = altOut[k];
        altDir  = altOe[k];
        claimed = 1'b1;
      end
    end
  end

  // Unclaimed line falls back to the port registers
  assign val = claimed ? altVal : dataQ;
  assign dir = claimed ? altDir : cfgQ[`PPB_CFG_DIR];

  // ----------------------------------------
  // Pad control
  // ----------------------------------------
  // Open drain releases the pin for a high level
  assign active   = rstn && (HAS_OUT != 0) && dir && !(cfgQ[`PPB_CFG_OD] && val);
  assign padOeN   = !active;
  assign padOut   = cfgQ[`PPB_CFG_OD] ? 1'b0 : val;
  assign pullUpEn = rstn && cfgQ[`PPB_CFG_PEN] && cfgQ[`PPB_CFG_PUP];
  assign pullDnEn = rstn && cfgQ[`PPB_CFG_PEN] && !cfgQ[`PPB_CFG_PUP];
  assign slowEdge = cfgQ[`PPB_CFG_SLOW];
  assign drive    = cfgQ[`PPB_CFG_DRV_HI:`PPB_CFG_DRV_LO];

endmodule

/* File: ppb_port_bank.v */
// Parallel I/O port bank: seven bidirectional and two input-only ports.
// Assumes a single-cycle register port and pads resolved by the surroundings.
//
// How it works
// - Reset forces inputs, pulls switched off
// - Input direction disables the output driver
// - Per-line direction, drain, pull, edge, strength; input-only lines keep only the pull bits
// - Single line access leaves others untouched
// - Alternate functions routable to several pins
// - Unclaimed lines are plain register-driven I/O
// - Seven bidirectional ports, two input-only ports
// - Widths 8,8,14,4,3,5,16; inputs 11,5
`include "ppb_defines.vh"

module ppb_port_bank #(
  parameter NALT  = `PPB_N_ALT,
  parameter NAIN  = `PPB_N_ALTIN
) (
  // Clock and reset
  input  wire                         clk,
  input  wire                         rstn,
  // Register port
  input  wire [`PPB_ADDR_W-1:0]       addr,
  input  wire [`PPB_DATA_W-1:0]       wdata,
  input  wire                         wrStb,
  input  wire                         rdStb,
  output reg  [`PPB_DATA_W-1:0]       rdata,
  // Alternate peripheral side
  input  wire [74*`PPB_N_ALT-1:0]     altOut,
  input  wire [74*`PPB_N_ALT-1:0]     altOe,
  output reg  [`PPB_N_ALTIN-1:0]      altIn,
  // Pads
  input  wire [73:0]                  padIn,
  output wire [73:0]                  padOut,
  output wire [73:0]                  padOeN,
  output wire [73:0]                  pullUpEn,
  output wire [73:0]                  pullDnEn,
  output wire [73:0]                  slowEdge,
  output wire [147:0]                 drive
);

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  // Bidirectional lines occupy the low indices, input-only lines the top
  localparam NBIDIR = `PPB_W_BIDIR0 + `PPB_W_BIDIR1 + `PPB_W_BIDIR2 + `PPB_W_BIDIR3
                    + `PPB_W_BIDIR4 + `PPB_W_BIDIR5 + `PPB_W_BIDIR6;
  localparam NINP   = `PPB_W_INONLY0 + `PPB_W_INONLY1;
  localparam NLINE  = NBIDIR + NINP;
  localparam [`PPB_IDX_W-1:0] NLINE_I = NLINE;
  localparam [`PPB_IDX_W-1:0] NAIN_I  = NAIN;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire [2:0]             kind;
  wire [`PPB_IDX_W-1:0]  idx;
  wire                   lineHit;
  wire                   routeHit;
  wire [NLINE-1:0]       cfgWr;
  wire [NLINE-1:0]       dataWr;
  wire [NLINE-1:0]       syncIn;
  wire [NLINE-1:0]       dataQ;
  wire [NLINE*`PPB_CFG_W-1:0] cfgQ;

  assign kind     = addr[`PPB_KIND_MSB:`PPB_KIND_LSB];
  assign idx      = addr[`PPB_IDX_W-1:0];
  assign lineHit  = (idx < NLINE_I);
  assign routeHit = (idx < NAIN_I);

  // ----------------------------------------
  // Lines
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NLINE; g = g + 1) begin : gLine
      assign cfgWr[g]  = wrStb && (kind == `PPB_KIND_CFG)  && (idx == g);
      assign dataWr[g] = wrStb && (kind == `PPB_KIND_DATA) && (idx == g);

      ppb_line #(
        .HAS_OUT (g < NBIDIR ? 1 : 0),
        .NALT    (NALT)
      ) uLine (
        .clk      (clk),
        .rstn     (rstn),
        .cfgWr    (cfgWr[g]),
        .dataWr   (dataWr[g]),
        .wdata    (wdata[`PPB_CFG_W-1:0]),
        .cfgQ     (cfgQ[g*`PPB_CFG_W +: `PPB_CFG_W]),
        .dataQ    (dataQ[g]),
        .syncIn   (syncIn[g]),
        .altOut   (altOut[g*NALT +: NALT]),
        .altOe    (altOe[g*NALT +: NALT]),
        .padIn    (padIn[g]),
        .padOut   (padOut[g]),
        .padOeN   (padOeN[g]),
        .pullUpEn (pullUpEn[g]),
        .pullDnEn (pullDnEn[g]),
        .slowEdge (slowEdge[g]),
        .drive    (drive[g*2 +: 2])
      );
    end
  endgenerate

  // ----------------------------------------
  // Alternate input routing
  // ----------------------------------------
  // Each peripheral input picks one synchronised pin
  reg [NAIN*`PPB_IDX_W-1:0] route_q;
  reg [`PPB_IDX_W-1:0]      sel;
  reg [NAIN-1:0]            altNext;
  integer                   j;

  always @(posedge clk) begin
    if (!rstn) begin
      route_q <= {NAIN*`PPB_IDX_W{1'b0}};
    end else if (wrStb && kind == `PPB_KIND_ROUTE && routeHit) begin
      route_q[idx*`PPB_IDX_W +: `PPB_IDX_W] <= wdata[`PPB_IDX_W-1:0];
    end
  end

  // Index beyond the last line reads as low
  always @* begin
    sel     = {`PPB_IDX_W{1'b0}};
    altNext = {NAIN{1'b0}};
    for (j = 0; j < NAIN; j = j + 1) begin
      sel = route_q[j*`PPB_IDX_W +: `PPB_IDX_W];
      if (sel < NLINE_I)
        altNext[j] = syncIn[sel];
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      altIn <= {NAIN{1'b0}};
    end else begin
      altIn <= altNext;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  reg [`PPB_DATA_W-1:0] rdNext;

  always @* begin
    rdNext = {`PPB_DATA_W{1'b0}};
    case (kind)
      `PPB_KIND_DATA: begin
        if (lineHit) begin
          rdNext[`PPB_DAT_IN]  = syncIn[idx];
          rdNext[`PPB_DAT_OUT] = dataQ[idx];
        end
      end
      `PPB_KIND_CFG: begin
        if (lineHit)
          rdNext[`PPB_CFG_W-1:0] = cfgQ[idx*`PPB_CFG_W +: `PPB_CFG_W];
      end
      `PPB_KIND_ROUTE: begin
        if (routeHit)
          rdNext[`PPB_IDX_W-1:0] = route_q[idx*`PPB_IDX_W +: `PPB_IDX_W];
      end
      default: rdNext = {`PPB_DATA_W{1'b0}};
    endcase
  end

  always @(posedge clk) begin
    if (!rstn)
      rdata <= {`PPB_DATA_W{1'b0}};
    else if (rdStb)
      rdata <= rdNext;
    else
      rdata <= {`PPB_DATA_W{1'b0}};
  end

endmodule

/* File: ppb_board_model.sv */
// Board side of the port bank: resolves each pin from drivers and pulls.
// Assumes active-low pad enables; lines without driver or pull float.
module ppb_board_model (
  // Clock
  input  logic        clk,
  // Pad controls
  input  logic [73:0] padOut,
  input  logic [73:0] padOeN,
  input  logic [73:0] pullUpEn,
  input  logic [73:0] pullDnEn,
  // Pin levels
  output logic [73:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flt_q = 1'b0;
  // Floating lines change every cycle
  always @(posedge clk) flt_q <= ~flt_q;
  assign padIn = (~padOeN & padOut) | (padOeN & pullUpEn) | (padOeN & ~pullUpEn & ~pullDnEn & {74{flt_q}});
endmodule

/* File: ppb_port_bank_checker.sv */
// Concurrent checks on the port bank's register port and pad controls.
// Assumes binding onto ppb_port_bank; one clock, synchronous low reset.
module ppb_port_bank_checker (
  // Clock and reset
  input  logic         clk,
  input  logic         rstn,
  // Register port
  input  logic [9:0]   addr,
  input  logic [15:0]  wdata,
  input  logic         wrStb,
  input  logic         rdStb,
  input  logic [15:0]  rdata,
  // Pads
  input  logic [73:0]  padIn,
  input  logic [73:0]  padOut,
  input  logic [73:0]  padOeN,
  input  logic [73:0]  pullUpEn,
  input  logic [73:0]  pullDnEn,
  input  logic [73:0]  slowEdge,
  input  logic [147:0] drive
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [73:0] h1_q, h2_q;
  logic        pinAtRd_q;
  // Pin history matching a two-stage synchroniser
  always @(posedge clk) begin
    h1_q      <= padIn;
    h2_q      <= h1_q;
    pinAtRd_q <= h2_q[addr[6:0]];
  end
  sequence s_cfgBi; wrStb && addr[9:7] == 3'h1 && addr[6:0] < 7'h3A; endsequence
  sequence s_cfgAny; wrStb && addr[9:7] == 3'h1 && addr[6:0] < 7'h4A; endsequence
  sequence s_datWr; wrStb && addr[9:7] == 3'h0 && addr[6:0] < 7'h3A; endsequence
  sequence s_datRd; rdStb && addr[9:7] == 3'h0 && addr[6:0] < 7'h4A; endsequence
  property p_rstOe; $rose(rstn) |-> &padOeN && !(|pullUpEn) && !(|pullDnEn); endproperty
  property p_inOnly; &padOeN[73:58]; endproperty
  property p_dir; s_cfgBi ##0 !wdata[1] && wdata[8:7] == 2'h0 |=> padOeN[$past(addr[6:0])] == !$past(wdata[0]);
  endproperty
  property p_drain; s_cfgBi ##0 wdata[1:0] == 2'h3 && wdata[8:7] == 2'h0 |=> !padOut[$past(addr[6:0])]; endproperty
  property p_pull; s_cfgAny |=> pullUpEn[$past(addr[6:0])] == ($past(wdata[2]) && $past(wdata[3]))
    && pullDnEn[$past(addr[6:0])] == ($past(wdata[2]) && !$past(wdata[3])); endproperty
  property p_shape; s_cfgBi |=> slowEdge[$past(addr[6:0])] == $past(wdata[4])
    && drive[$past(addr[6:0]) * 2 +: 2] == $past(wdata[6:5]); endproperty
  property p_latch; s_datWr ##1 rdStb && $stable(addr) |=> rdata[1] == $past(wdata[0], 2); endproperty
  property p_sync; s_datRd ##0 $past(rstn) && $past(rstn, 2) |=> rdata[0] == pinAtRd_q; endproperty
  property p_rdIdle; !rdStb |=> rdata == 16'h0000; endproperty
  property p_rstSafe; disable iff (1'b0) !rstn |-> &padOeN && !(|pullUpEn) && !(|pullDnEn); endproperty
  a_rstOe: assert property (p_rstOe) else $error("pads not safe after reset");
  a_inOnly: assert property (p_inOnly) else $error("input-only line driven");
  a_dir: assert property (p_dir) else $error("direction not applied");
  a_drain: assert property (p_drain) else $error("open-drain value not 0");
  a_pull: assert property (p_pull) else $error("pull enables wrong");
  a_shape: assert property (p_shape) else $error("edge or strength wrong");
  a_latch: assert property (p_latch) else $error("latch readback wrong");
  a_sync: assert property (p_sync) else $error("input sample wrong");
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  a_rstSafe: assert property (p_rstSafe) else $error("pads not safe during reset");
endmodule
bind ppb_port_bank ppb_port_bank_checker ppb_port_bank_checker_i (.clk(clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .padIn(padIn), .padOut(padOut),
  .padOeN(padOeN), .pullUpEn(pullUpEn), .pullDnEn(pullDnEn), .slowEdge(slowEdge), .drive(drive));

/* File: ppb_port_bank_tb.sv */
// Self-checking bench of the port bank over its register port.
// Assumes the board model resolves pins; all waits are fixed counts.
module ppb_port_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, rstn, wrStb, rdStb;
  logic [9:0]   addr;
  logic [15:0]  wdata;
  logic [221:0] altOut, altOe;
  wire  [15:0]  rdata, altIn;
  wire  [73:0]  padIn, padOut, padOeN, pullUpEn, pullDnEn, slowEdge;
  wire  [147:0] drive;
  int           n_fail = 0;
  int           samples_checked = 0;
  ppb_port_bank ppb_port_bank_i (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wrStb(wrStb),
    .rdStb(rdStb), .rdata(rdata), .altOut(altOut), .altOe(altOe), .altIn(altIn), .padIn(padIn),
    .padOut(padOut), .padOeN(padOeN), .pullUpEn(pullUpEn), .pullDnEn(pullDnEn), .slowEdge(slowEdge),
    .drive(drive));
  ppb_board_model ppb_board_model_i (.clk(clk), .padOut(padOut), .padOeN(padOeN), .pullUpEn(pullUpEn),
    .pullDnEn(pullDnEn), .padIn(padIn));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    wrStb <= w;
    rdStb <= r;
    addr  <= a;
    wdata <= d;
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 10'h000, 16'h0000);
    #1;
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    bus(1'b0, 1'b1, a, 16'h0000);
    idle(1);
    chk(rdata, e);
  endtask
  task automatic stop_test;
    $display("n_fail=%0d samples_checked=%0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rstn   = 1'b0;
    wrStb  = 1'b0;
    rdStb  = 1'b0;
    addr   = 10'h000;
    wdata  = 16'h0000;
    altOut = '0;
    altOe  = '0;
    repeat (2) @(posedge clk);
    #1 chk({padOeN[15:0] ^ 16'hFFFF} | pullUpEn[15:0] | pullDnEn[15:0], 16'h0000);
    @(posedge clk) rstn <= 1'b1;
    wr(10'h080, 16'h0001);
    wr(10'h000, 16'h0001);
    idle(3);
    chk({padOeN[0], padOut[0]}, 16'h0001);
    wr(10'h000, 16'h0001);
    rd(10'h000, 16'h0003);
    wr(10'h001, 16'h0000);
    idle(1);
    chk(padOut[0], 16'h0001);
    wr(10'h082, 16'h0003);
    wr(10'h002, 16'h0000);
    idle(1);
    chk({padOeN[2], padOut[2]}, 16'h0000);
    wr(10'h002, 16'h0001);
    idle(1);
    chk(padOeN[2], 16'h0001);
    wr(10'h0B9, 16'h0071);
    wr(10'h0BA, 16'h0001);
    idle(1);
    chk({slowEdge[57], drive[115:114], padOeN[57]}, 16'h000E);
    chk(padOeN[73:58], 16'hFFFF);
    rd(10'h0B9, 16'h0071);
    rd(10'h0BA, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      wr(10'h0BC, k ? 16'h0004 : 16'h000C);
      idle(1);
      chk({pullUpEn[60], pullDnEn[60]}, k ? 16'h0001 : 16'h0002);
      idle(3);
      rd(10'h03C, k ? 16'h0000 : 16'h0001);
    end
    @(posedge clk) begin
      altOe[10]  <= 1'b1;
      altOut[10] <= 1'b1;
      altOe[0]   <= 1'b1;
      altOut[0]  <= 1'b0;
    end
    wr(10'h083, 16'h0100);
    wr(10'h003, 16'h0000);
    wr(10'h100, 16'h0003);
    idle(1);
    chk({padOeN[3], padOut[3], padOut[0]}, 16'h0003);
    idle(4);
    chk(altIn[0], 16'h0001);
    rd(10'h083, 16'h0100);
    rd(10'h100, 16'h0003);
    rd(10'h180, 16'h0000);
    rd(10'h04A, 16'h0000);
    @(posedge clk) rstn <= 1'b0;
    #1 chk({padOeN[3:0], pullDnEn[60]}, 16'h001E);
    @(posedge clk) rstn <= 1'b1;
    idle(2);
    chk({padOeN[3:0], pullDnEn[60], padOut[0]}, 16'h003C);
    rd(10'h080, 16'h0000);
    rd(10'h100, 16'h0000);
    stop_test();
  end
endmodule
